// [pkg/afr_cfg.svh]
// Offsets, field positions, reset values and timing figures of the post-filter block
`ifndef AFR_CFG_SVH
`define AFR_CFG_SVH

// Register word indices on the plain register port
`define AFR_REG_FILTER 4'h0
`define AFR_REG_ERR_EN 4'h1
`define AFR_REG_ERROR 4'h2
`define AFR_REG_STATUS 4'h3
`define AFR_REG_DATA 4'h4
`define AFR_REG_OFFSET 4'h5
`define AFR_REG_GAIN 4'h6
`define AFR_REG_IRQ_STAT 4'h7
`define AFR_REG_IRQ_MASK 4'h8

// Filter configuration layout
`define AFR_FLT_TYPE_LSB 0
`define AFR_FLT_POST_LSB 3
`define AFR_FLT_PWR_LSB 6
`define AFR_FLT_SIXTY_HZ_NOTCH_OPTION_BIT 8
`define AFR_FLT_MULTI_BIT 9
`define AFR_FLT_EXTREF_BIT 10
`define AFR_FLT_TYPE_POST 3'h7
`define AFR_FLT_TYPE_SINC3 3'h2
`define AFR_FLT_TYPE_SINC4 3'h0

// Flag bit positions
`define AFR_ERREN_REF_BIT 0
`define AFR_ERROR_REF_BIT 0
`define AFR_STATUS_ERR_BIT 0
`define AFR_STATUS_RDY_BIT 1
`define AFR_IRQ_RDY_BIT 0
`define AFR_IRQ_REF_BIT 1

// Reset values, and the all-ones result forced on a reference fault
`define AFR_RST_FILTER 11'h000
`define AFR_RST_ERR_EN 1'h0
`define AFR_RST_COEF 24'h800000
`define AFR_ALL_ONES 24'hffffff

// Timing: clock rate and times in microseconds
`define AFR_CLK_MHZ 40
`define AFR_T_SET_27_FULL_US 38498
`define AFR_T_SET_27_MID_US 38998
`define AFR_T_SET_27_LOW_US 39662
`define AFR_T_SET_25_FULL_US 41831
`define AFR_T_SET_25_MID_US 42331
`define AFR_T_SET_25_LOW_US 42995
`define AFR_T_SET_20_FULL_US 51831
`define AFR_T_SET_20_MID_US 52331
`define AFR_T_SET_20_LOW_US 52995
`define AFR_T_SET_16_FULL_US 61831
`define AFR_T_SET_16_MID_US 62331
`define AFR_T_SET_16_LOW_US 62995
`define AFR_T_PER_27_US 36670
`define AFR_T_PER_25_US 40000
`define AFR_T_PER_20_US 50000
`define AFR_T_PER_16_US 60000
`define AFR_CYC(us) ((us) * `AFR_CLK_MHZ)

`endif

// [pkg/afr_pkg.sv]
// Types shared by the post-filter block and its settling timer
package afr_pkg;

   typedef struct packed {
      logic valid;
      logic [23:0] data;
   } afr_sample_t;

   typedef struct packed {
      logic ext_ref;
      logic multi;
      logic sixty_hz_notch_option;
      logic [1:0] power;
      logic [2:0] post_sel;
      logic [2:0] ftype;
   } afr_filter_t;

   typedef enum logic [2:0] {
      AFR_T_IDLE = 3'b001,
      AFR_T_SETTLE = 3'b010,
      AFR_T_RUN = 3'b100
   } afr_tstate_t;

   typedef struct packed {
      afr_tstate_t st;
      logic [23:0] cnt;
      logic tick;
   } afr_tmr_t;

   typedef struct packed {
      logic lo_s1;
      logic lo_s2;
      logic op_s1;
      logic op_s2;
      afr_filter_t flt;
      logic chk_en;
      logic ref_flag;
      logic [23:0] data;
      logic data_rdy;
      logic [23:0] offset;
      logic [23:0] gain;
      logic cal_busy;
      logic cal_fault;
      logic [23:0] hold3;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic irq;
      logic notch60;
      logic [31:0] rdata;
      afr_sample_t res;
   } afr_top_t;

endpackage : afr_pkg

// [logic/afr_settle_timer.sv]
// Settling and output-rate timer for the post-filter path
`timescale 1ns/1ps
`default_nettype none
module afr_settle_timer (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   input wire logic i_run,
   input wire logic i_restart,
   input wire logic i_multi,
   input wire logic [23:0] i_settle_cyc,
   input wire logic [23:0] i_period_cyc,
   output logic o_tick
);
   import afr_pkg::*;

   afr_tmr_t s;
   afr_tmr_t n;
   logic [23:0] tgt;

   always_comb begin
      n = s;
      n.tick = 1'b0;
      tgt = (s.st == AFR_T_RUN) ? i_period_cyc : i_settle_cyc;
      if (!i_run) begin
         n.st = AFR_T_IDLE;
         n.cnt = 24'h000000;
      end else if (i_restart || s.st == AFR_T_IDLE) begin
         n.st = AFR_T_SETTLE;
         n.cnt = 24'h000000;
      end else begin
         case (s.st)
            AFR_T_SETTLE, AFR_T_RUN: begin
               if (s.cnt >= tgt - 24'h000001) begin
                  n.tick = 1'b1;
                  n.cnt = 24'h000000;
                  // Multi-channel: each result waits a whole settling time
                  n.st = i_multi ? AFR_T_SETTLE : AFR_T_RUN;
               end else begin
                  n.cnt = s.cnt + 24'h000001;
               end
            end
            default: begin
               n.st = AFR_T_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s <= '{st: AFR_T_IDLE, cnt: 24'h000000, tick: 1'b0};
      end else if (i_clk_en) begin
         s <= n;
      end
   end

   assign o_tick = s.tick;

   chk_first_settle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_clk_en && i_run && !i_restart && s.st == AFR_T_SETTLE && n.tick)
      |-> (s.cnt == i_settle_cyc - 24'h000001))
      else $error("settling result at wrong count");
   chk_later_period: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_clk_en && i_run && !i_restart && s.st == AFR_T_RUN && n.tick)
      |-> (s.cnt == i_period_cyc - 24'h000001))
      else $error("later result off the output rate");
   chk_multi_resettle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_clk_en && i_run && !i_restart && i_multi && n.tick)
      |=> (s.st == AFR_T_SETTLE && s.cnt == 24'h000000))
      else $error("multi-channel result without full settling");

endmodule : afr_settle_timer
`default_nettype wire

// [logic/afr_top.sv]
// Post-filter output stage with settling control and reference detect
//
// What this block does
// - Post-filter path is used only when filter type field is all ones.
// - Post-filter selection field picks which post-filter variant applies.
// - Post filter takes its samples from the third-order sinc stage.
// - Single channel: first result after settling, then at output rate.
// - Several channels: every result waits a full settling time.
// - Settling of 27.27 and 25 SPS options per power mode.
// - Settling of 20 and 16.67 SPS options per power mode.
// - Sixty hertz notch option adds a 60 Hz notch to sinc filters.
// - Reference check runs only when enabled and external reference used.
// - Low or open reference sets the reference fault flag.
// - Reference fault flag also sets the status summary error bit.
// - Conversion results become all ones while a reference fault stands.
// - Reference fault during calibration leaves coefficient unchanged, flag set.
// - Standby exit may raise the flag; host reads error register after.
// - Error flags clear only on a host read of the error register.
`timescale 1ns/1ps
`default_nettype none
`include "afr_cfg.svh"
module afr_top #(
   parameter int unsigned P_SETTLE_CYC [12] = '{
      `AFR_CYC(`AFR_T_SET_27_FULL_US), `AFR_CYC(`AFR_T_SET_27_MID_US),
      `AFR_CYC(`AFR_T_SET_27_LOW_US), `AFR_CYC(`AFR_T_SET_25_FULL_US),
      `AFR_CYC(`AFR_T_SET_25_MID_US), `AFR_CYC(`AFR_T_SET_25_LOW_US),
      `AFR_CYC(`AFR_T_SET_20_FULL_US), `AFR_CYC(`AFR_T_SET_20_MID_US),
      `AFR_CYC(`AFR_T_SET_20_LOW_US), `AFR_CYC(`AFR_T_SET_16_FULL_US),
      `AFR_CYC(`AFR_T_SET_16_MID_US), `AFR_CYC(`AFR_T_SET_16_LOW_US)},
   parameter int unsigned P_PERIOD_CYC [4] = '{
      `AFR_CYC(`AFR_T_PER_27_US), `AFR_CYC(`AFR_T_PER_25_US),
      `AFR_CYC(`AFR_T_PER_20_US), `AFR_CYC(`AFR_T_PER_16_US)}
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire afr_pkg::afr_sample_t i_sinc3,
   input wire afr_pkg::afr_sample_t i_sinc4,
   input wire logic i_conv_active,
   input wire logic i_chan_switch,
   input wire logic i_ref_low,
   input wire logic i_ref_open,
   input wire logic i_standby_exit,
   input wire logic i_cal_start,
   input wire logic i_cal_done,
   input wire logic i_cal_is_gain,
   input wire logic [23:0] i_cal_coef,
   output afr_pkg::afr_sample_t o_result,
   output logic o_notch60_en,
   output logic o_irq
);
   import afr_pkg::*;

   afr_top_t s;
   afr_top_t n;
   logic tick;
   logic post_en;
   logic opt_ok;
   logic mon_active;
   logic fault_now;
   logic forced;
   logic fire;
   logic restart;
   logic [23:0] val;
   logic [23:0] settle_cyc;
   logic [23:0] period_cyc;
   logic [1:0] pwr_idx;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
      hit = (a == r);
   endfunction : hit

   assign post_en = (s.flt.ftype == `AFR_FLT_TYPE_POST);
   assign opt_ok = (s.flt.post_sel < 3'h4);
   // Power code 3 has no table entry and falls back to low power
   assign pwr_idx = (s.flt.power == 2'h3) ? 2'h2 : s.flt.power;
   // Table indexed by option, then power mode
   assign settle_cyc = 24'(P_SETTLE_CYC[s.flt.post_sel[1:0] * 3 + pwr_idx]);
   assign period_cyc = 24'(P_PERIOD_CYC[s.flt.post_sel[1:0]]);
   assign restart = i_chan_switch || (i_wr && hit(i_addr, `AFR_REG_FILTER));
   assign mon_active = s.chk_en && s.flt.ext_ref
      && (i_conv_active || s.cal_busy);
   assign fault_now = mon_active && (s.lo_s2 || s.op_s2);
   assign forced = fault_now || s.ref_flag;

   afr_settle_timer u_timer (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_clk_en(i_clk_en),
      .i_run(post_en && opt_ok && i_conv_active),
      .i_restart(restart),
      .i_multi(s.flt.multi),
      .i_settle_cyc(settle_cyc),
      .i_period_cyc(period_cyc),
      .o_tick(tick)
   );

   always_comb begin
      n = s;
      n.lo_s1 = i_ref_low;
      n.lo_s2 = s.lo_s1;
      n.op_s1 = i_ref_open;
      n.op_s2 = s.op_s1;
      n.rdata = 32'h00000000;
      fire = 1'b0;
      val = s.hold3;

      // Register writes; status clears precede the sets below
      if (i_wr) begin
         case (i_addr)
            `AFR_REG_FILTER: n.flt = afr_filter_t'(i_wdata[10:0]);
            `AFR_REG_ERR_EN: n.chk_en = i_wdata[`AFR_ERREN_REF_BIT];
            `AFR_REG_IRQ_STAT: n.irq_stat = s.irq_stat & ~i_wdata[1:0];
            `AFR_REG_IRQ_MASK: n.irq_mask = i_wdata[1:0];
            default: n.rdata = 32'h00000000;
         endcase
      end

      // Register reads; data answers one cycle later
      if (i_rd) begin
         case (i_addr)
            `AFR_REG_FILTER: n.rdata = {21'h000000, s.flt};
            `AFR_REG_ERR_EN: n.rdata = {31'h00000000, s.chk_en};
            `AFR_REG_ERROR: begin
               n.rdata = {31'h00000000, s.ref_flag};
               n.ref_flag = 1'b0;
            end
            `AFR_REG_STATUS: begin
               n.rdata = {30'h00000000, s.data_rdy, s.ref_flag};
            end
            `AFR_REG_DATA: begin
               n.rdata = {8'h00, s.data};
               n.data_rdy = 1'b0;
            end
            `AFR_REG_OFFSET: n.rdata = {8'h00, s.offset};
            `AFR_REG_GAIN: n.rdata = {8'h00, s.gain};
            `AFR_REG_IRQ_STAT: n.rdata = {30'h00000000, s.irq_stat};
            `AFR_REG_IRQ_MASK: n.rdata = {30'h00000000, s.irq_mask};
            default: n.rdata = 32'h00000000;
         endcase
      end

      // Post path keeps the newest third-order sinc sample only
      if (i_sinc3.valid) begin
         n.hold3 = i_sinc3.data;
      end

      if (post_en) begin
         fire = tick;
         val = s.hold3;
      end else if (s.flt.ftype == `AFR_FLT_TYPE_SINC3) begin
         fire = i_sinc3.valid && i_conv_active;
         val = i_sinc3.data;
      end else begin
         fire = i_sinc4.valid && i_conv_active;
         val = i_sinc4.data;
      end

      n.res.valid = fire;
      n.res.data = forced ? `AFR_ALL_ONES : val;
      if (fire) begin
         n.data = n.res.data;
         n.data_rdy = 1'b1;
         n.irq_stat[`AFR_IRQ_RDY_BIT] = 1'b1;
      end

      // Fault sets win over a same-cycle read clear
      if (fault_now || (i_standby_exit && s.chk_en)) begin
         n.ref_flag = 1'b1;
         n.irq_stat[`AFR_IRQ_REF_BIT] = 1'b1;
      end

      // A fault seen at any point of a calibration blocks its coefficient
      if (i_cal_start) begin
         n.cal_busy = 1'b1;
         n.cal_fault = 1'b0;
      end else if (s.cal_busy && fault_now) begin
         n.cal_fault = 1'b1;
      end
      if (i_cal_done && s.cal_busy) begin
         n.cal_busy = 1'b0;
         if (!s.cal_fault && !fault_now) begin
            if (i_cal_is_gain) begin
               n.gain = i_cal_coef;
            end else begin
               n.offset = i_cal_coef;
            end
         end
      end

      // The notch belongs to the plain sinc modes, not the post filters
      n.notch60 = n.flt.sixty_hz_notch_option && (n.flt.ftype == `AFR_FLT_TYPE_SINC4
         || n.flt.ftype == `AFR_FLT_TYPE_SINC3);
      n.irq = |(n.irq_stat & n.irq_mask);
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s <= '0;
         s.flt <= afr_filter_t'(`AFR_RST_FILTER);
         s.chk_en <= `AFR_RST_ERR_EN;
         s.offset <= `AFR_RST_COEF;
         s.gain <= `AFR_RST_COEF;
      end else if (i_clk_en) begin
         s <= n;
      end
   end

   assign o_rdata = s.rdata;
   assign o_result = s.res;
   assign o_notch60_en = s.notch60;
   assign o_irq = s.irq;

   chk_post_only_tick: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (i_clk_en && post_en && !tick) |=> !o_result.valid)
      else $error("post path produced a result off the timer");
   chk_post_sinc3_src: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (i_clk_en && post_en && tick && !forced)
      |=> (o_result.valid && o_result.data == $past(s.hold3)))
      else $error("post result not from sinc3 sample");
   chk_ref_sets: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (i_clk_en && mon_active && (s.lo_s2 || s.op_s2)) |=> s.ref_flag)
      else $error("reference fault missed");
   chk_ref_gated: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (i_clk_en && !mon_active && !i_standby_exit && !s.ref_flag)
      |=> !s.ref_flag)
      else $error("reference flag set while check inactive");
   chk_status_err: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (i_clk_en && i_rd && i_addr == `AFR_REG_STATUS && s.ref_flag)
      |=> o_rdata[`AFR_STATUS_ERR_BIT])
      else $error("status error bit not shown");
   chk_ones_forced: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (i_clk_en && fire && forced)
      |=> (o_result.data == `AFR_ALL_ONES && s.data == `AFR_ALL_ONES))
      else $error("faulted result not all ones");
   chk_cal_blocked: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (i_clk_en && i_cal_done && (s.cal_fault || fault_now))
      |=> ($stable(s.offset) && $stable(s.gain) && s.ref_flag))
      else $error("coefficient updated despite reference fault");
   chk_flag_sticky: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (i_clk_en && s.ref_flag && !(i_rd && i_addr == `AFR_REG_ERROR))
      |=> s.ref_flag)
      else $error("reference flag cleared without error read");
   chk_standby_flag: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (i_clk_en && i_standby_exit && s.chk_en) |=> s.ref_flag)
      else $error("standby exit did not raise flag");
   chk_notch_option: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (i_clk_en && post_en) |=> !o_notch60_en)
      else $error("notch enabled with post filter");

endmodule : afr_top
`default_nettype wire

// [testbench/afr_host_model.sv]
// Host-side register master for the post-filter block
`timescale 1ns/1ps
`default_nettype none
`include "afr_cfg.svh"
module afr_host_model (
   input wire logic i_sys_clk,
   output logic [3:0] o_addr,
   output logic [31:0] o_wdata,
   output logic o_wr,
   output logic o_rd,
   input wire logic [31:0] i_rdata
);
   initial begin
      o_addr = 4'h0;
      o_wdata = 32'h0;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end

   // Returns at the edge that takes the write
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_sys_clk);
      o_wr <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the read edge
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_sys_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_sys_clk);
      o_rd <= 1'b0;
      #1;
      d = i_rdata;
   endtask : rd

   // Polling is wasted effort: the flag only matters behind all ones
   task automatic result_check(input logic [23:0] r, output logic f);
      logic [31:0] e;
      f = 1'b0;
      if (r === 24'hffffff) begin
         rd(`AFR_REG_ERROR, e);
         f = e[0];
      end
   endtask : result_check

   // After calibration or standby exit; the read also clears the flag
   task automatic err_after_event(output logic f);
      logic [31:0] e;
      rd(`AFR_REG_ERROR, e);
      f = e[0];
   endtask : err_after_event
endmodule : afr_host_model
`default_nettype wire

// [testbench/tb_afr_top.sv]
// Self-checking bench for the post-filter block
`timescale 1ns/1ps
`default_nettype none
`include "afr_cfg.svh"
module tb_afr_top;
   import afr_pkg::*;
   // Short counts keep the run small; periods stay below every settle
   localparam int unsigned ST [12] = '{20, 22, 24, 26, 28, 30, 32, 34, 36,
      38, 40, 42};
   localparam int unsigned PR [4] = '{10, 12, 14, 16};
   logic sys_clk, rst_n, clk_en, wr, rd, conv, chsw, rlow, ropen, sbx;
   logic cst, cdone, cgain, notch, irq;
   logic [3:0] addr;
   logic [31:0] wdata, rdata;
   logic [23:0] ccoef;
   afr_sample_t s3, s4, res;
   int mismatches, total_checks;

   afr_top #(.P_SETTLE_CYC(ST), .P_PERIOD_CYC(PR)) DUT (
      .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_clk_en(clk_en),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .i_sinc3(s3), .i_sinc4(s4), .i_conv_active(conv),
      .i_chan_switch(chsw), .i_ref_low(rlow), .i_ref_open(ropen),
      .i_standby_exit(sbx), .i_cal_start(cst), .i_cal_done(cdone),
      .i_cal_is_gain(cgain), .i_cal_coef(ccoef), .o_result(res),
      .o_notch60_en(notch), .o_irq(irq)
   );
   afr_host_model host (
      .i_sys_clk(sys_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
      .o_rd(rd), .i_rdata(rdata)
   );
   always #12.5 sys_clk = ~sys_clk;

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] d;
      host.rd(a, d);
      chk(d, exp);
   endtask : rchk

   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : step

   function automatic logic [31:0] flt(int t, int o, int p, int r, int m,
      int x);
      return 32'(t + (o << 3) + (p << 6) + (r << 8) + (m << 9) + (x << 10));
   endfunction : flt

   // The result stands only in the cycle after the sample edge, so it is
   // taken here before the next edge can drop it
   task automatic samp(input logic [23:0] a, input logic [23:0] b,
      output logic [23:0] d);
      @(posedge sys_clk);
      s3 <= {1'b1, a};
      s4 <= {1'b1, b};
      @(posedge sys_clk);
      s3.valid <= 1'b0;
      s4.valid <= 1'b0;
      #1;
      chk(32'(res.valid), 32'h1);
      d = res.data;
   endtask : samp

   // Edges counted until a result; lim + 1 means none came
   task automatic wait_res(input int lim, input bit must, output int n,
      output logic [23:0] d);
      n = lim + 1;
      d = 24'h0;
      for (int i = 1; i <= lim; i++) begin
         step(1);
         if (res.valid === 1'b1) begin
            n = i;
            d = res.data;
            break;
         end
      end
      if (must && n > lim) begin
         mismatches++;
         $display("[ERR] %0t no result in time", $time);
         test_done();
      end
   endtask : wait_res

   task automatic t_reset();
      rchk(`AFR_REG_FILTER, 32'h0);
      rchk(`AFR_REG_ERR_EN, 32'h0);
      rchk(`AFR_REG_OFFSET, 32'h800000);
      rchk(`AFR_REG_GAIN, 32'h800000);
      host.wr(4'hf, 32'hffffffff);
      rchk(4'hf, 32'h0);
   endtask : t_reset

   task automatic t_sinc();
      logic [23:0] d;
      conv <= 1'b1;
      for (int t = 0; t < 3; t++) begin
         host.wr(`AFR_REG_FILTER, flt(t == 2 ? 7 : t * 2, 0, 0, 1, 0, 0));
         step(2);
         chk(32'(notch), t == 2 ? 32'h0 : 32'h1);
         if (t < 2) begin
            samp(24'h0a0a0a, 24'h0b0b0b, d);
            chk(32'(d), t == 0 ? 32'h0b0b0b : 32'h0a0a0a);
         end
      end
   endtask : t_sinc

   task automatic t_post();
      int n, s, p;
      logic [23:0] d;
      for (int o = 0; o < 4; o++) begin
         for (int w = 0; w < 3; w++) begin
            s = ST[o * 3 + w];
            p = PR[o];
            s3 <= {1'b1, 24'(24'h300000 + o * 3 + w)};
            s4 <= {1'b1, 24'h0f0f0f};
            host.wr(`AFR_REG_FILTER, flt(7, o, w, 0, 0, 0));
            // Result lands one cycle after the settle count ends
            wait_res(60, 1'b1, n, d);
            if (o + w == 0) begin
               chk(32'(n - s), 32'h1);
            end
            chk(32'(n), 32'(s + 1));
            chk(32'(d), 32'h300000 + 32'(o * 3 + w));
            wait_res(60, 1'b1, n, d);
            chk(32'(n), 32'(p));
         end
      end
      @(posedge sys_clk);
      chsw <= 1'b1;
      @(posedge sys_clk);
      chsw <= 1'b0;
      wait_res(60, 1'b1, n, d);
      chk(32'(n >= ST[11] && n <= ST[11] + 4), 32'h1);
      host.wr(`AFR_REG_FILTER, flt(7, 4, 0, 0, 0, 0));
      wait_res(60, 1'b0, n, d);
      chk(32'(n), 32'd61);
      host.wr(`AFR_REG_FILTER, flt(7, 0, 0, 0, 0, 0));
      conv <= 1'b0;
      wait_res(60, 1'b0, n, d);
      chk(32'(n), 32'd61);
      conv <= 1'b1;
      host.wr(`AFR_REG_FILTER, flt(7, 1, 0, 0, 1, 0));
      repeat (2) begin
         wait_res(60, 1'b1, n, d);
         chk(32'(n >= ST[3] && n <= ST[3] + 4), 32'h1);
      end
      s3.valid <= 1'b0;
      s4.valid <= 1'b0;
   endtask : t_post

   task automatic t_ref();
      logic [31:0] d;
      logic f;
      logic [23:0] r;
      host.wr(`AFR_REG_FILTER, flt(0, 0, 0, 0, 0, 1));
      rlow <= 1'b1;
      step(5);
      rchk(`AFR_REG_ERROR, 32'h0);
      // Internal reference first, so arming the check cannot catch a fault
      host.wr(`AFR_REG_FILTER, flt(0, 0, 0, 0, 0, 0));
      host.wr(`AFR_REG_ERR_EN, 32'h1);
      step(5);
      rchk(`AFR_REG_ERROR, 32'h0);
      host.wr(`AFR_REG_FILTER, flt(0, 0, 0, 0, 0, 1));
      step(5);
      host.rd(`AFR_REG_STATUS, d);
      chk(32'(d[0]), 32'h1);
      samp(24'h123456, 24'h654321, r);
      chk(32'(r), 32'hffffff);
      rchk(`AFR_REG_DATA, 32'hffffff);
      rlow <= 1'b0;
      step(5);
      samp(24'h123456, 24'h654321, r);
      host.result_check(r, f);
      chk(32'(f), 32'h1);
      rchk(`AFR_REG_ERROR, 32'h0);
      host.rd(`AFR_REG_STATUS, d);
      chk(32'(d[0]), 32'h0);
      samp(24'h123456, 24'h654321, r);
      chk(32'(r), 32'h654321);
      ropen <= 1'b1;
      step(5);
      ropen <= 1'b0;
      step(5);
      rchk(`AFR_REG_ERROR, 32'h1);
      rchk(`AFR_REG_ERROR, 32'h0);
      @(posedge sys_clk);
      sbx <= 1'b1;
      @(posedge sys_clk);
      sbx <= 1'b0;
      host.err_after_event(f);
      chk(32'(f), 32'h1);
      rchk(`AFR_REG_ERROR, 32'h0);
   endtask : t_ref

   task automatic cal(input logic g, input logic [23:0] c, input logic bad);
      @(posedge sys_clk);
      cst <= 1'b1;
      @(posedge sys_clk);
      cst <= 1'b0;
      ropen <= bad;
      step(5);
      ropen <= 1'b0;
      step(5);
      cdone <= 1'b1;
      cgain <= g;
      ccoef <= c;
      @(posedge sys_clk);
      cdone <= 1'b0;
      step(2);
   endtask : cal

   // Conversions stay off so that only calibration arms the check
   task automatic t_cal();
      logic f;
      conv <= 1'b0;
      ropen <= 1'b1;
      step(5);
      ropen <= 1'b0;
      step(5);
      rchk(`AFR_REG_ERROR, 32'h0);
      cal(1'b0, 24'h123456, 1'b0);
      rchk(`AFR_REG_OFFSET, 32'h123456);
      host.err_after_event(f);
      chk(32'(f), 32'h0);
      cal(1'b1, 24'h654321, 1'b1);
      rchk(`AFR_REG_GAIN, 32'h800000);
      host.err_after_event(f);
      chk(32'(f), 32'h1);
      cal(1'b1, 24'h654321, 1'b0);
      rchk(`AFR_REG_GAIN, 32'h654321);
      conv <= 1'b1;
   endtask : t_cal

   task automatic t_irq();
      logic [23:0] r;
      host.wr(`AFR_REG_IRQ_MASK, 32'h0);
      host.wr(`AFR_REG_IRQ_STAT, 32'h3);
      samp(24'h000001, 24'h000002, r);
      chk(32'(r), 32'h000002);
      rchk(`AFR_REG_IRQ_STAT, 32'h1);
      chk(32'(irq), 32'h0);
      host.wr(`AFR_REG_IRQ_MASK, 32'h1);
      step(2);
      chk(32'(irq), 32'h1);
      // A frozen block must ignore the clear and keep its interrupt
      clk_en <= 1'b0;
      host.wr(`AFR_REG_IRQ_STAT, 32'h1);
      step(2);
      chk(32'(irq), 32'h1);
      clk_en <= 1'b1;
      host.wr(`AFR_REG_IRQ_STAT, 32'h1);
      step(2);
      chk(32'(irq), 32'h0);
      rchk(`AFR_REG_IRQ_STAT, 32'h0);
   endtask : t_irq

   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      clk_en = 1'b1;
      {conv, chsw, rlow, ropen, sbx, cst, cdone, cgain} = 8'h0;
      ccoef = 24'h0;
      s3 = '0;
      s4 = '0;
      step(5);
      chk({7'h0, res}, 32'h0);
      chk(32'(irq), 32'h0);
      @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_sinc();
      t_post();
      t_ref();
      t_cal();
      t_irq();
      test_done();
   end
endmodule : tb_afr_top
`default_nettype wire
